// *** core/scfad_pkg.sv ***
// Package for the serial character-format block: offsets, fields, timing.
// Assumes a byte-wide register port with read data one cycle after the strobe.
package scfad_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFF_HOLDING  = 8'hf8;
	localparam logic [7:0] OFF_PRIO     = 8'hf9;
	localparam logic [7:0] OFF_FORMAT   = 8'hfa;
	localparam logic [7:0] OFF_COMPARE  = 8'hfb;
	localparam logic [7:0] OFF_STATUS   = 8'hfc;
	localparam logic [7:0] OFF_MODE     = 8'hfd;
	localparam logic [7:0] OFF_COUNT    = 8'hfe;
	// ==========================================================
	// Priority/control fields
	localparam int PRIO_ADDR_EN   = 7;
	localparam int PRIO_BREAK     = 6;
	localparam int PRIO_ADDR_SEND = 5;
	localparam int PRIO_RX_DMA    = 4;
	localparam int PRIO_TX_DMA    = 3;
	// ==========================================================
	// Format fields
	localparam int FMT_ADDR_SEL   = 7;
	localparam int FMT_PAR_TYPE   = 6;
	localparam int FMT_PAR_EN     = 5;
	localparam int FMT_NINTH_EN   = 4;
	localparam int FMT_STOP_LO    = 2;
	localparam int FMT_WORD_LO    = 0;
	// ==========================================================
	// Status fields
	localparam int ST_ADDR_PEND   = 4;
	localparam int ST_FRAME_ERR   = 6;
	localparam int ST_PAR_ERR     = 5;
	localparam int ST_DATA_PEND   = 2;
	localparam int ST_HOLD_EMPTY  = 1;
	localparam int ST_SHIFT_EMPTY = 0;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_PRIO   = 8'h07;
	localparam logic [7:0] RST_FORMAT = 8'h03;
	localparam logic [7:0] RST_STATUS = 8'h03;
	// ==========================================================
	// Timing in half clock periods: per bit and 16X start offset; minimum data bits
	localparam logic [5:0] HALVES_16X = 6'h20;
	localparam logic [5:0] HALVES_1X  = 6'h02;
	localparam logic [4:0] HALF_16X   = 5'h08;
	localparam int MIN_WORD_DATA      = 5;
endpackage

// *** core/scfad_core.sv ***
// Character-format serial port: holding registers, framing, address filter,
// break, DMA enables and priority. Assumes synchronous inputs on clk.
//
// Decided for this implementation: the plain strobed port.
module scfad_core (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic [7:0]      rdata,
	input  wire logic       rx_in,
	output logic            tx_out,
	output logic            rx_dma_req,
	output logic            tx_dma_req,
	output logic [1:0]      req_sel,
	output logic            req_valid,
	output logic [2:0]      req_level
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef enum logic [4:0] {
		TX_IDLE  = 5'h01,
		TX_SEND  = 5'h02,
		TX_BRK   = 5'h04,
		TX_MARK  = 5'h08,
		TX_WAIT  = 5'h10
	} scfad_tx_e;
	typedef enum logic [2:0] {
		RX_IDLE  = 3'h1,
		RX_RECV  = 3'h2,
		RX_DONE  = 3'h4
	} scfad_rx_e;

	logic [7:0]  prio_ff, fmt_ff, cmp_ff, status_ff, rx_hold_ff, tx_hold_ff;
	logic        mode_1x_ff, tx_full_ff, tx_addr_ff, after_brk_ff, pass_ff;
	logic [7:0]  count_ff;
	scfad_tx_e   tx_st_ff;
	scfad_rx_e   rx_st_ff;
	logic [11:0] tx_sh_ff, rx_sh_ff;
	logic [3:0]  tx_bits_ff, rx_bits_ff;
	logic [5:0]  tx_half_ff, rx_half_ff;
	logic        brk_done_ff, rx_zero_ff;
	logic [3:0]  frame_len, data_len;
	logic [5:0]  bit_halves;
	logic [5:0]  stop_halves;
	logic [5:0]  stop_clks;
	logic        par_bit, tx_load;

	// ==========================================================
	// Format decode
	// word length
	assign data_len = 4'(scfad_pkg::MIN_WORD_DATA) + {2'b00, fmt_ff[1:0]};
	assign bit_halves = mode_1x_ff ? scfad_pkg::HALVES_1X : scfad_pkg::HALVES_16X;
	always_comb begin
		case (fmt_ff[3:2])
			2'b00:   stop_halves = 6'd2;
			2'b01:   stop_halves = mode_1x_ff ? 6'd4 : 6'd3;
			2'b10:   stop_halves = 6'd4;
			default: stop_halves = mode_1x_ff ? 6'd6 : 6'd5;
		endcase
	end
	// Stop time in whole clocks; 2.5 stops in 16X is 40 clocks, fits 6 bits
	assign stop_clks = mode_1x_ff ? {1'b0, stop_halves[5:1]} : {stop_halves[2:0], 3'b000};
	// Data, parity and ninth bit count after start
	assign frame_len = data_len + {3'b000, fmt_ff[scfad_pkg::FMT_PAR_EN]}
		+ {3'b000, fmt_ff[scfad_pkg::FMT_NINTH_EN]};
	// odd when type 0, even when 1; ninth bit excluded
	assign par_bit = ^(tx_hold_ff & (8'hff >> (4'd8 - data_len)))
		^ ~fmt_ff[scfad_pkg::FMT_PAR_TYPE];
	// load once shift register is free
	assign tx_load = tx_st_ff == TX_IDLE && tx_full_ff;

	// ==========================================================
	// Register writes
	always_ff @(posedge clk) begin
		if (reset) begin
			fmt_ff     <= scfad_pkg::RST_FORMAT;
			cmp_ff     <= 8'h00;
			mode_1x_ff <= 1'b0;
			count_ff   <= 8'h00;
		end else if (wr) begin
			if (addr == scfad_pkg::OFF_FORMAT)  fmt_ff     <= wdata;
			if (addr == scfad_pkg::OFF_COMPARE) cmp_ff     <= wdata;
			if (addr == scfad_pkg::OFF_MODE)    mode_1x_ff <= wdata[0];
			if (addr == scfad_pkg::OFF_COUNT)   count_ff   <= wdata;
		end else if ((rx_dma_req || tx_dma_req) && count_ff != 8'h00) begin
			count_ff <= count_ff - 8'h01;
		end
	end

	// Priority/control register with hardware clears
	always_ff @(posedge clk) begin
		if (reset) begin
			prio_ff <= scfad_pkg::RST_PRIO;
		end else begin
			if (wr && addr == scfad_pkg::OFF_PRIO) prio_ff <= wdata;
			if (tx_load) prio_ff[scfad_pkg::PRIO_ADDR_SEND] <= 1'b0;
			if (count_ff == 8'h01 && (rx_dma_req || tx_dma_req)) begin
				prio_ff[scfad_pkg::PRIO_RX_DMA] <= 1'b0;
				prio_ff[scfad_pkg::PRIO_TX_DMA] <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Transmit holding
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_hold_ff <= 8'h00;
			tx_full_ff <= 1'b0;
		end else if (wr && addr == scfad_pkg::OFF_HOLDING) begin
			tx_hold_ff <= wdata;
			tx_full_ff <= 1'b1;
		end else if (tx_load) begin
			tx_full_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Transmitter
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_st_ff    <= TX_IDLE;
			tx_sh_ff    <= 12'hfff;
			tx_bits_ff  <= 4'h0;
			tx_half_ff  <= 6'h00;
			tx_out      <= 1'b1;
			tx_addr_ff  <= 1'b0;
			brk_done_ff <= 1'b0;
		end else begin
			case (tx_st_ff)
				TX_IDLE: begin
					tx_out <= 1'b1;
					if (tx_full_ff) begin
						// frame assembly; upper bits forced to one by length
						tx_sh_ff   <= {4'hf, tx_hold_ff} & ~(12'hfff << data_len)
							| (12'hfff << data_len);
						if (fmt_ff[scfad_pkg::FMT_PAR_EN])
							tx_sh_ff[data_len] <= par_bit;
						tx_addr_ff <= prio_ff[scfad_pkg::PRIO_ADDR_SEND];
						tx_out     <= 1'b0;
						tx_bits_ff <= 4'h0;
						tx_half_ff <= 6'h00;
						tx_st_ff   <= TX_SEND;
					end else if (prio_ff[scfad_pkg::PRIO_BREAK]) begin
						// break only when both registers idle
						tx_out      <= 1'b0;
						tx_bits_ff  <= 4'h0;
						tx_half_ff  <= 6'h00;
						brk_done_ff <= 1'b0;
						tx_st_ff    <= TX_BRK;
					end
				end
				TX_SEND: begin
					tx_half_ff <= tx_half_ff + 6'd2;
					if (tx_half_ff + 6'd2 >= bit_halves && tx_bits_ff <= frame_len) begin
						tx_half_ff <= 6'h00;
						tx_bits_ff <= tx_bits_ff + 4'h1;
						// parity then ninth bit then stops
						if (fmt_ff[scfad_pkg::FMT_NINTH_EN] && tx_bits_ff == frame_len - 4'h1)
							tx_out <= tx_addr_ff;
						else if (tx_bits_ff == frame_len)
							tx_out <= 1'b1;
						else
							tx_out <= tx_sh_ff[tx_bits_ff];
					end else if (tx_bits_ff > frame_len) begin
						// stop counted in clocks; idle cycle starts the next word
						tx_half_ff <= tx_half_ff + 6'd1;
						if (tx_half_ff + 6'd2 >= stop_clks) tx_st_ff <= TX_IDLE;
					end
				end
				TX_BRK: begin
					// at least one whole word, then while bit set
					tx_half_ff <= tx_half_ff + 6'd2;
					if (tx_half_ff + 6'd2 >= bit_halves) begin
						tx_half_ff <= 6'h00;
						if (tx_bits_ff <= frame_len + 4'h1)
							tx_bits_ff <= tx_bits_ff + 4'h1;
						else
							brk_done_ff <= 1'b1;
					end
					if (brk_done_ff && !prio_ff[scfad_pkg::PRIO_BREAK]) begin
						tx_out     <= 1'b1;
						tx_half_ff <= 6'h00;
						tx_st_ff   <= TX_MARK;
					end
				end
				TX_MARK: begin
					tx_half_ff <= tx_half_ff + 6'd2;
					if (tx_half_ff + 6'd2 >= bit_halves) tx_st_ff <= TX_IDLE;
				end
				default: tx_st_ff <= TX_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Receiver, sampled three quarters into each bit in 16X
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_st_ff   <= RX_IDLE;
			rx_sh_ff   <= 12'h000;
			rx_bits_ff <= 4'h0;
			rx_half_ff <= 6'h00;
			rx_zero_ff <= 1'b0;
		end else begin
			case (rx_st_ff)
				RX_IDLE: if (!rx_in) begin
					rx_half_ff <= mode_1x_ff ? 6'h00 : {1'b0, scfad_pkg::HALF_16X};
					// In 1X the detecting sample already was the start bit
					rx_bits_ff <= mode_1x_ff ? 4'h1 : 4'h0;
					rx_zero_ff <= 1'b1;
					rx_st_ff   <= RX_RECV;
				end
				RX_RECV: begin
					rx_half_ff <= rx_half_ff + 6'd2;
					if (rx_half_ff + 6'd2 >= bit_halves) begin
						rx_half_ff <= 6'h00;
						rx_bits_ff <= rx_bits_ff + 4'h1;
						if (rx_bits_ff != 4'h0) rx_sh_ff[rx_bits_ff - 4'h1] <= rx_in;
						if (rx_in) rx_zero_ff <= 1'b0;
						if (rx_bits_ff == frame_len + 4'h1) rx_st_ff <= RX_DONE;
					end
				end
				RX_DONE: if (rx_in) rx_st_ff <= RX_IDLE;
				default: rx_st_ff <= RX_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Receive word end: filtering and flags
	logic       rx_end, rx_ninth, rx_match, rx_is_addr, rx_par_ok, rx_brk;
	logic [7:0] rx_data;
	assign rx_end   = rx_st_ff == RX_RECV && rx_half_ff + 6'd2 >= bit_halves
		&& rx_bits_ff == frame_len + 4'h1;
	assign rx_brk   = rx_end && rx_zero_ff && !rx_in;
	// unused upper bits forced to one
	assign rx_data  = rx_sh_ff[7:0] | (8'hff << data_len);
	assign rx_ninth = fmt_ff[scfad_pkg::FMT_NINTH_EN] && rx_sh_ff[frame_len - 4'h1];
	assign rx_match = rx_data == cmp_ff;
	always_comb begin
		case ({prio_ff[scfad_pkg::PRIO_ADDR_EN], fmt_ff[scfad_pkg::FMT_ADDR_SEL]})
			2'b00:   rx_is_addr = rx_ninth;
			2'b01:   rx_is_addr = rx_match;
			2'b10:   rx_is_addr = rx_match && rx_ninth;
			default: rx_is_addr = rx_match && after_brk_ff;
		endcase
	end
	assign rx_par_ok = (^(rx_sh_ff[7:0] & ~(8'hff << data_len)) ^ rx_sh_ff[data_len]
		^ ~fmt_ff[scfad_pkg::FMT_PAR_TYPE]) == 1'b0;

	always_ff @(posedge clk) begin
		if (reset) begin
			status_ff    <= scfad_pkg::RST_STATUS;
			rx_hold_ff   <= 8'hff;
			pass_ff      <= 1'b1;
			after_brk_ff <= 1'b0;
		end else begin
			// Software clears; hardware sets below win
			if (wr && addr == scfad_pkg::OFF_STATUS) status_ff <= status_ff & wdata;
			if (rd && addr == scfad_pkg::OFF_HOLDING)
				status_ff[scfad_pkg::ST_DATA_PEND] <= 1'b0;
			if (rx_end) after_brk_ff <= rx_brk;
			if (rx_end && !rx_brk) begin
				status_ff[scfad_pkg::ST_FRAME_ERR] <= !rx_in;
				if (fmt_ff[scfad_pkg::FMT_PAR_EN] && !rx_par_ok)
					status_ff[scfad_pkg::ST_PAR_ERR] <= 1'b1;
				if (rx_is_addr) begin
					status_ff[scfad_pkg::ST_ADDR_PEND] <= 1'b1;
					pass_ff <= 1'b1;
				end else if (fmt_ff[scfad_pkg::FMT_NINTH_EN] && rx_ninth
						&& prio_ff[scfad_pkg::PRIO_ADDR_EN]) begin
					pass_ff <= 1'b0;
				end else if (pass_ff) begin
					rx_hold_ff <= rx_data;
					status_ff[scfad_pkg::ST_DATA_PEND] <= 1'b1;
				end
			end
			// empty flags track the holding register and the shift path
			status_ff[scfad_pkg::ST_HOLD_EMPTY]  <= !tx_full_ff || tx_load;
			status_ff[scfad_pkg::ST_SHIFT_EMPTY] <= tx_st_ff == TX_IDLE && !tx_full_ff;
		end
	end

	// ==========================================================
	// Requests and priority
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_dma_req <= 1'b0;
			tx_dma_req <= 1'b0;
			req_sel    <= 2'b00;
			req_valid  <= 1'b0;
			req_level  <= 3'h7;
		end else begin
			rx_dma_req <= prio_ff[scfad_pkg::PRIO_RX_DMA] && status_ff[scfad_pkg::ST_DATA_PEND];
			tx_dma_req <= prio_ff[scfad_pkg::PRIO_TX_DMA] && status_ff[scfad_pkg::ST_HOLD_EMPTY];
			req_level  <= prio_ff[2:0];
			req_valid  <= prio_ff[2:0] != 3'h7 && (status_ff[scfad_pkg::ST_DATA_PEND]
				|| status_ff[scfad_pkg::ST_HOLD_EMPTY] || status_ff[scfad_pkg::ST_ADDR_PEND]);
			if (prio_ff[scfad_pkg::PRIO_RX_DMA] && status_ff[scfad_pkg::ST_DATA_PEND])
				req_sel <= 2'b00;
			else if (prio_ff[scfad_pkg::PRIO_TX_DMA] && status_ff[scfad_pkg::ST_HOLD_EMPTY])
				req_sel <= 2'b01;
			else if (status_ff[scfad_pkg::ST_DATA_PEND] || status_ff[scfad_pkg::ST_ADDR_PEND])
				req_sel <= 2'b10;
			else
				req_sel <= 2'b11;
		end
	end

	// ==========================================================
	// Read data, one cycle after strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				scfad_pkg::OFF_HOLDING: rdata <= rx_hold_ff;
				scfad_pkg::OFF_PRIO:    rdata <= prio_ff;
				scfad_pkg::OFF_FORMAT:  rdata <= fmt_ff;
				scfad_pkg::OFF_COMPARE: rdata <= cmp_ff;
				scfad_pkg::OFF_STATUS:  rdata <= status_ff;
				scfad_pkg::OFF_MODE:    rdata <= {7'h00, mode_1x_ff};
				scfad_pkg::OFF_COUNT:   rdata <= count_ff;
				default:                rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule

// *** test/scfad_sva.sv ***
// Checker for the serial character-format block, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
module scfad_sva (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       rx_in,
	input wire logic       tx_out,
	input wire logic       rx_dma_req,
	input wire logic       tx_dma_req,
	input wire logic [1:0] req_sel,
	input wire logic       req_valid,
	input wire logic [2:0] req_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] fmt_ff;
	logic [2:0] lvl_w;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// ==========================================================
	// Shadow of the format register
	assign lvl_w = wdata[2:0];
	always_ff @(posedge clk) begin
		if (reset)
			fmt_ff <= 8'h03;
		else if (wr && addr == 8'hfa)
			fmt_ff <= wdata;
	end
	// ==========================================================
	// Assertions
	a_reset_idle: assert property (disable iff (1'b0)
		reset |=> tx_out && req_level == 3'h7 && rdata == 8'h00)
		else $error("Outputs not idle after reset");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("Read data outside read cycle");
	a_unmapped_rd: assert property (
		rd && (addr < 8'hf8 || addr == 8'hff) |=> rdata == 8'h00)
		else $error("Unmapped read not zero");
	a_level_write: assert property (
		wr && addr == 8'hf9 ##1 !(wr && addr == 8'hf9) |=> req_level == $past(lvl_w, 2))
		else $error("Priority level not taken");
	a_no_prio: assert property (req_level == 3'h7 [*2] |-> !req_valid)
		else $error("Request at level seven");
	a_rank_rx: assert property (
		rx_dma_req && req_level != 3'h7 |-> ##[0:1] (req_valid && req_sel == 2'h0))
		else $error("Receive DMA not ranked first");
	a_rank_tx: assert property (
		tx_dma_req && !rx_dma_req && req_level != 3'h7
		|-> ##[0:1] (req_valid && req_sel == 2'h1))
		else $error("Transmit DMA not ranked second");
	a_format_read: assert property (
		rd && addr == 8'hfa |=> rdata == $past(fmt_ff))
		else $error("Format read back wrong");
	c_rx_dma: cover property (rx_dma_req);
	c_tx_dma: cover property (tx_dma_req);
	c_rx_irq: cover property (req_valid && req_sel == 2'h2);
	c_tx_start: cover property ($fell(tx_out));
endmodule

// *** test/scfad_station.sv ***
// Remote serial station: drives the receive line, samples the transmit line.
// Assumes both lines idle high and bit times in whole clk periods.
module scfad_station (
	input  wire logic clk,
	input  wire logic tx_line,
	output logic      rx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rx_line = 1'b1;
	// ==========================================================
	// start low, data LSB first
	task automatic send(input logic [11:0] v, input int n, input int per);
		for (int i = 0; i < n; i++) begin
			rx_line <= v[i];
			repeat (per) @(posedge clk);
		end
		rx_line <= 1'b1;
		repeat (2 * per) @(posedge clk);
	endtask
	// Line held low, then idle
	task automatic brk(input int len);
		rx_line <= 1'b0;
		repeat (len) @(posedge clk);
		rx_line <= 1'b1;
		repeat (40) @(posedge clk);
	endtask
	// Waits for a start bit, samples mid-bit
	task automatic grab(output logic [11:0] v, input int n, input int per);
		int w;
		v = 12'h000;
		w = 0;
		while (tx_line !== 1'b0 && w < 400) begin
			@(posedge clk);
			w++;
		end
		repeat (per / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			v[i] = tx_line;
			repeat (per) @(posedge clk);
		end
	endtask
endmodule

// *** test/serial_char_format_addr_dma_tb.sv ***
// Testbench for the serial character-format block with a remote station.
// Assumes the register port answers reads one cycle after the strobe.
module serial_char_format_addr_dma_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] ADR = 32'h42414210;
	localparam logic [3:0] PEND = 4'hb;
	logic       clk, reset, wr, rd, rx_in, tx_out;
	logic       rx_dma_req, tx_dma_req, req_valid;
	logic [7:0] addr, wdata, rdata;
	logic [1:0] req_sel;
	logic [2:0] req_level;
	int         n_errors, total_checks;
	scfad_core u_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .rx_in(rx_in), .tx_out(tx_out), .rx_dma_req(rx_dma_req),
		.tx_dma_req(tx_dma_req), .req_sel(req_sel), .req_valid(req_valid),
		.req_level(req_level));
	scfad_station u_station (.clk(clk), .tx_line(tx_out), .rx_line(rx_in));
	// Clock
	initial clk = 1'b0;
	always #5 clk = ~clk;
	// ==========================================================
	// Bus cycles and comparison
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic chk8(input string what, input logic [7:0] ex, input logic [7:0] got);
		total_checks++;
		if (got !== ex) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, ex, got);
		end
	endtask
	// Expected frame bits, start bit first
	function automatic logic [11:0] frame(input logic [7:0] d, input int n, input logic pe,
		input logic ep, input logic ne, input logic nb, output int len);
		logic [11:0] v;
		logic        p;
		v = 12'h000;
		p = ~ep;
		len = 1;
		for (int i = 0; i < n; i++) begin
			v[len] = d[i];
			p = p ^ d[i];
			len++;
		end
		if (pe) begin
			v[len] = p;
			len++;
		end
		if (ne) begin
			v[len] = nb;
			len++;
		end
		v[len] = 1'b1;
		len++;
		return v;
	endfunction
	task automatic tx_one(input logic [7:0] d, input int n, input int per, input logic [11:0] ex);
		logic [11:0] got;
		fork
			u_station.grab(got, n, per);
			wr_reg(8'hf8, d);
		join
		chk8("tx low", ex[7:0], got[7:0]);
		chk8("tx high", {4'h0, ex[11:8]}, {4'h0, got[11:8]});
		repeat (2 * per) @(posedge clk);
	endtask
	task automatic watch(input logic rxs, output logic seen);
		seen = 1'b0;
		repeat (300) begin
			@(posedge clk);
			if ((rxs ? rx_dma_req : tx_dma_req) === 1'b1)
				seen = 1'b1;
		end
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [7:0] d;
		rd_reg(8'hf9, d);
		chk8("priority reset", 8'h07, d);
		rd_reg(8'hfa, d);
		chk8("format reset", 8'h03, d);
		rd_reg(8'hff, d);
		chk8("unmapped read", 8'h00, d);
		chk8("level out", 8'h07, {5'h00, req_level});
	endtask
	task automatic t_tx();
		int          len;
		logic [11:0] ex;
		logic [7:0]  d;
		wr_reg(8'hfd, 8'h01);
		for (int w = 0; w < 4; w++) begin
			wr_reg(8'hfa, {1'b0, w[0], 4'h8, w[1:0]});
			ex = frame(8'ha5, w + 5, 1'b1, w[0], 1'b0, 1'b0, len);
			tx_one(8'ha5, len, 1, ex);
		end
		wr_reg(8'hfa, 8'h33);
		wr_reg(8'hf9, 8'h23);
		ex = frame(8'h3c, 8, 1'b1, 1'b0, 1'b1, 1'b1, len);
		tx_one(8'h3c, len, 1, ex);
		rd_reg(8'hf9, d);
		chk8("address send cleared", 8'h03, d);
		wr_reg(8'hfd, 8'h00);
		wr_reg(8'hfa, 8'h03);
		ex = frame(8'h5a, 8, 1'b0, 1'b0, 1'b0, 1'b0, len);
		tx_one(8'h5a, len, 16, ex);
	endtask
	task automatic t_rx();
		int          len;
		logic [11:0] v;
		logic [7:0]  d;
		wr_reg(8'hfa, 8'h00);
		wr_reg(8'hf9, 8'h03);
		v = frame(8'h16, 5, 1'b0, 1'b0, 1'b0, 1'b0, len);
		u_station.send(v, len, 16);
		rd_reg(8'hfc, d);
		chk8("data pending", 8'h01, {7'h00, d[2]});
		chk8("rank rx irq", 8'h06, {5'h00, req_valid, req_sel});
		rd_reg(8'hf8, d);
		chk8("short char", 8'hf6, d);
		wr_reg(8'hf8, 8'h00);
		rd_reg(8'hf8, d);
		chk8("holding split", 8'hf6, d);
		// Odd parity configured; even-parity frame must flag an error
		wr_reg(8'hfa, 8'h23);
		for (int e = 0; e < 2; e++) begin
			wr_reg(8'hfc, 8'h00);
			v = frame(8'h5e, 8, 1'b1, e[0], 1'b0, 1'b0, len);
			u_station.send(v, len, 16);
			rd_reg(8'hfc, d);
			chk8("parity error", {7'h00, e[0]}, {7'h00, d[5]});
		end
	endtask
	task automatic t_stop();
		int         n, m;
		logic [7:0] ex;
		for (int s = 1; s < 4; s += 2) begin
			wr_reg(8'hfa, {4'h0, s[1:0], 2'b11});
			ex = (s == 1) ? 8'h18 : 8'h28;
			wr_reg(8'hf8, 8'h00);
			wr_reg(8'hf8, 8'h00);
			m = 0;
			n = 0;
			while (tx_out !== 1'b1 && m < 400) begin
				@(posedge clk);
				m++;
			end
			while (tx_out === 1'b1 && n < 100) begin
				@(posedge clk);
				n++;
			end
			chk8("stop length", ex, n[7:0]);
			repeat (220) @(posedge clk);
		end
	endtask
	task automatic t_addr();
		int          len;
		logic [11:0] v;
		logic [7:0]  d;
		wr_reg(8'hfb, 8'h42);
		for (int m = 0; m < 4; m++) begin
			wr_reg(8'hfa, {m[0], 7'h13});
			wr_reg(8'hf9, {m[1], 7'h03});
			if (m == 3) begin
				u_station.brk(400);
				rd_reg(8'hf8, d);
			end
			wr_reg(8'hfc, 8'h00);
			v = frame(ADR[8*m +: 8], 8, 1'b0, 1'b0, 1'b1, 1'b1, len);
			u_station.send(v, len, 16);
			rd_reg(8'hfc, d);
			chk8("address pending", {7'h00, PEND[m]}, {7'h00, d[4]});
			chk8("address kept out", 8'h00, {7'h00, d[2]});
			wr_reg(8'hfc, 8'h00);
			v = frame(8'h77, 8, 1'b0, 1'b0, 1'b1, 1'b0, len);
			u_station.send(v, len, 16);
			rd_reg(8'hfc, d);
			chk8("data passed", {7'h00, PEND[m]}, {7'h00, d[2]});
			rd_reg(8'hf8, d);
		end
	endtask
	task automatic t_brk();
		int n;
		wr_reg(8'hfd, 8'h01);
		wr_reg(8'hfa, 8'h03);
		for (int h = 0; h < 2; h++) begin
			wr_reg(8'hf9, 8'h43);
			n = 0;
			fork
				begin
					repeat (40 * h) @(posedge clk);
					wr_reg(8'hf9, 8'h03);
				end
				for (int i = 0; i < 90; i++) begin
					@(posedge clk);
					n += (tx_out === 1'b0);
				end
			join
			chk8("break length", 8'h01, {7'h00, n >= (h ? 40 : 10)});
			chk8("break end", 8'h01, {7'h00, tx_out});
		end
	endtask
	task automatic t_dma();
		int          len;
		logic [11:0] v;
		logic [7:0]  d;
		logic        seen;
		wr_reg(8'hfd, 8'h00);
		wr_reg(8'hfe, 8'h02);
		wr_reg(8'hf9, 8'h0b);
		watch(1'b0, seen);
		chk8("tx dma seen", 8'h01, {7'h00, seen});
		rd_reg(8'hf9, d);
		chk8("tx dma cleared", 8'h03, d);
		wr_reg(8'hfe, 8'h05);
		wr_reg(8'hf9, 8'h13);
		v = frame(8'h5e, 8, 1'b0, 1'b0, 1'b0, 1'b0, len);
		fork
			u_station.send(v, len, 16);
			watch(1'b1, seen);
		join
		chk8("rx dma seen", 8'h01, {7'h00, seen});
		rd_reg(8'hf9, d);
		chk8("rx dma cleared", 8'h03, d);
	endtask
	// ==========================================================
	// Verdict, main sequence, watchdog
	task automatic give_verdict();
		$display("Checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		n_errors = 0;
		total_checks = 0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_tx();
		t_stop();
		t_rx();
		t_addr();
		t_brk();
		t_dma();
		give_verdict();
	end
	initial begin
		#200000;
		n_errors++;
		give_verdict();
	end
endmodule
bind scfad_core scfad_sva u_sva (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .rx_in(rx_in), .tx_out(tx_out),
	.rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req), .req_sel(req_sel),
	.req_valid(req_valid), .req_level(req_level));
